// ==== design/rim_top.v ====
// Regulator interrupt mask registers and event gating
`timescale 1ns/1ns
`include "rim_consts.vh"

// Timing hazards for users of this block:
// The reset-event mask takes its OTP value at the first edge after reset,
// so a host write landing on that same edge is lost.
// A read in the same cycle as a write to that register returns the old value.
// Raw copies reset to zero, so a detector already high at release
// counts as an event at the first edge after release.
// Set pulses and raw status copies leave this block; the flag registers live outside.
module rim_top
#(
	parameter AW = `RIM_ADDR_W,
	parameter DW = `RIM_DATA_W
)
(
	input wire clk_i, // Register clock
	input wire rst_n_i, // Async device reset, active low
	input wire [AW-1:0] reg_addr_i, // Register address from serial port
	input wire [DW-1:0] reg_wdata_i, // Write data
	input wire reg_we_i, // Write strobe, one cycle
	input wire reg_re_i, // Read strobe, one cycle
	output reg [DW-1:0] reg_rdata_o, // Read data, valid after read strobe
	input wire otp_reset_mask_i, // OTP value of reset-event mask
	input wire reset_evt_i, // Register-reset event pulse
	input wire conv0_pg_i, // Converter 0 power-good detect, 1 = invalid
	input wire conv0_climit_i, // Converter 0 current limit detect
	input wire conv1_pg_i, // Converter 1 power-good detect
	input wire conv1_climit_i, // Converter 1 current limit detect
	input wire lin0_pg_i, // Linear 0 power-good detect
	input wire lin0_climit_i, // Linear 0 current limit detect
	input wire lin1_pg_i, // Linear 1 power-good detect
	input wire lin1_climit_i, // Linear 1 current limit detect
	output reg reset_flag_set_o, // Register-reset flag set pulse
	output wire [3:0] pg_raw_o, // Raw pg: lin1,lin0,conv1,conv0
	output wire [3:0] climit_raw_o, // Raw climit, same order
	output wire [3:0] pg_flag_set_o, // Pg flag set pulses, same order
	output wire [3:0] climit_flag_set_o // Climit flag set pulses
);

	reg [DW-1:0] reset_event_mask_q;
	reg [DW-1:0] buck_event_mask_q;
	reg [DW-1:0] linear_reg_event_mask_q;
	reg otp_load_q;
	reg [DW-1:0] rdata_d;
	wire [3:0] pg_in;
	wire [3:0] climit_in;
	wire [3:0] fall_mask;
	wire [3:0] rise_mask;
	wire [3:0] climit_mask;
	wire wr_reset;
	wire wr_conv;
	wire wr_lin;

	assign wr_reset = reg_we_i & (reg_addr_i == `RIM_ADDR_RESET_MASK);
	assign wr_conv = reg_we_i & (reg_addr_i == `RIM_ADDR_CONV_MASK);
	assign wr_lin = reg_we_i & (reg_addr_i == `RIM_ADDR_LIN_MASK);

	// Reset-event mask: OTP reload one cycle after release
	// Async reset may only load a constant, so OTP is caught by clock
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reset_event_mask_q <= `RIM_RST_RESET_MASK;
			otp_load_q <= 1'b1;
		end
		else if (otp_load_q)
		begin
			reset_event_mask_q[`RIM_BIT_RESET_MASK] <= otp_reset_mask_i;
			otp_load_q <= 1'b0;
		end
		else if (wr_reset)
		begin
			reset_event_mask_q <= reg_wdata_i;
		end
	end

	// Converter and linear masks; reserved bits never stored
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			buck_event_mask_q <= `RIM_RST_CONV_MASK;
			linear_reg_event_mask_q <= `RIM_RST_LIN_MASK;
		end
		else
		begin
			if (wr_conv)
			begin
				buck_event_mask_q <= reg_wdata_i & `RIM_PAIR_WMASK;
			end
			if (wr_lin)
			begin
				linear_reg_event_mask_q <= reg_wdata_i & `RIM_PAIR_WMASK;
			end
		end
	end

	// Read mux; unmapped addresses return zero
	always @*
	begin
		case (reg_addr_i)
			`RIM_ADDR_RESET_MASK: rdata_d = reset_event_mask_q;
			`RIM_ADDR_CONV_MASK: rdata_d = buck_event_mask_q;
			`RIM_ADDR_LIN_MASK: rdata_d = linear_reg_event_mask_q;
			default: rdata_d = `RIM_RD_UNMAPPED;
		endcase
	end

	// Registered read data, held until next read
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= `RIM_RD_UNMAPPED;
		end
		else if (reg_re_i)
		begin
			reg_rdata_o <= rdata_d;
		end
	end

	// Register-reset event gating
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reset_flag_set_o <= 1'b0;
		end
		else
		begin
			reset_flag_set_o <= reset_evt_i
				& ~reset_event_mask_q[`RIM_BIT_RESET_MASK];
		end
	end

	// Per-regulator mask selection: index 0,1 converters, 2,3 linear
	assign pg_in = {lin1_pg_i, lin0_pg_i, conv1_pg_i, conv0_pg_i};
	assign climit_in = {lin1_climit_i, lin0_climit_i,
		conv1_climit_i, conv0_climit_i};
	assign fall_mask = {linear_reg_event_mask_q[`RIM_BIT_R1_FALL],
		linear_reg_event_mask_q[`RIM_BIT_R0_FALL],
		buck_event_mask_q[`RIM_BIT_R1_FALL],
		buck_event_mask_q[`RIM_BIT_R0_FALL]};
	assign rise_mask = {linear_reg_event_mask_q[`RIM_BIT_R1_RISE],
		linear_reg_event_mask_q[`RIM_BIT_R0_RISE],
		buck_event_mask_q[`RIM_BIT_R1_RISE],
		buck_event_mask_q[`RIM_BIT_R0_RISE]};
	assign climit_mask = {linear_reg_event_mask_q[`RIM_BIT_R1_CLIM],
		linear_reg_event_mask_q[`RIM_BIT_R0_CLIM],
		buck_event_mask_q[`RIM_BIT_R1_CLIM],
		buck_event_mask_q[`RIM_BIT_R0_CLIM]};

	// One gate per regulator, named so each path is easy to find
	// Converter 0
	rim_event_gate u_conv0_gate
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pg_raw_i(pg_in[0]),
		.climit_raw_i(climit_in[0]),
		.fall_mask_i(fall_mask[0]),
		.rise_mask_i(rise_mask[0]),
		.climit_mask_i(climit_mask[0]),
		.pg_raw_o(pg_raw_o[0]),
		.climit_raw_o(climit_raw_o[0]),
		.pg_flag_set_o(pg_flag_set_o[0]),
		.climit_flag_set_o(climit_flag_set_o[0])
	);

	// Converter 1
	rim_event_gate u_conv1_gate
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pg_raw_i(pg_in[1]),
		.climit_raw_i(climit_in[1]),
		.fall_mask_i(fall_mask[1]),
		.rise_mask_i(rise_mask[1]),
		.climit_mask_i(climit_mask[1]),
		.pg_raw_o(pg_raw_o[1]),
		.climit_raw_o(climit_raw_o[1]),
		.pg_flag_set_o(pg_flag_set_o[1]),
		.climit_flag_set_o(climit_flag_set_o[1])
	);

	// Linear regulator 0
	rim_event_gate u_lin0_gate
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pg_raw_i(pg_in[2]),
		.climit_raw_i(climit_in[2]),
		.fall_mask_i(fall_mask[2]),
		.rise_mask_i(rise_mask[2]),
		.climit_mask_i(climit_mask[2]),
		.pg_raw_o(pg_raw_o[2]),
		.climit_raw_o(climit_raw_o[2]),
		.pg_flag_set_o(pg_flag_set_o[2]),
		.climit_flag_set_o(climit_flag_set_o[2])
	);

	// Linear regulator 1
	rim_event_gate u_lin1_gate
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pg_raw_i(pg_in[3]),
		.climit_raw_i(climit_in[3]),
		.fall_mask_i(fall_mask[3]),
		.rise_mask_i(rise_mask[3]),
		.climit_mask_i(climit_mask[3]),
		.pg_raw_o(pg_raw_o[3]),
		.climit_raw_o(climit_raw_o[3]),
		.pg_flag_set_o(pg_flag_set_o[3]),
		.climit_flag_set_o(climit_flag_set_o[3])
	);

endmodule

// ==== design/rim_consts.vh ====
// Constants for the regulator interrupt mask block
`ifndef RIM_CONSTS_VH
`define RIM_CONSTS_VH
`define RIM_ADDR_W 8
`define RIM_DATA_W 8
`define RIM_ADDR_RESET_MASK 8'h21
`define RIM_ADDR_CONV_MASK 8'h22
`define RIM_ADDR_LIN_MASK 8'h23
// Field positions within the converter, linear and reset-event masks
`define RIM_BIT_R1_FALL 7
`define RIM_BIT_R1_RISE 6
`define RIM_BIT_R1_CLIM 4
`define RIM_BIT_R0_FALL 3
`define RIM_BIT_R0_RISE 2
`define RIM_BIT_R0_CLIM 0
`define RIM_BIT_RESET_MASK 0
// Writable bits; reserved bits 5 and 1 stay zero
`define RIM_PAIR_WMASK 8'hdd
// Reset values
`define RIM_RST_RESET_MASK 8'h01
`define RIM_RST_CONV_MASK 8'hcc
`define RIM_RST_LIN_MASK 8'hcc
`define RIM_RD_UNMAPPED 8'h00
`endif

// ==== design/rim_event_gate.v ====
// Event detection and mask gating for one regulator
`timescale 1ns/1ns
module rim_event_gate
(
	input wire clk_i, // Register clock
	input wire rst_n_i, // Async reset, active low
	input wire pg_raw_i, // Detected power-good condition, 1 = invalid
	input wire climit_raw_i, // Detected current limit, 1 = active
	input wire fall_mask_i, // Invalid-detection mask
	input wire rise_mask_i, // Valid-detection mask
	input wire climit_mask_i, // Current-limit mask
	output reg pg_raw_o, // Raw power-good status
	output reg climit_raw_o, // Raw current-limit status
	output reg pg_flag_set_o, // Power-good flag set pulse
	output reg climit_flag_set_o // Current-limit flag set pulse
);

	wire pg_invalid_evt;
	wire pg_valid_evt;
	wire climit_evt;

	// Edges taken against the registered raw copy
	assign pg_invalid_evt = pg_raw_i & ~pg_raw_o;
	assign pg_valid_evt = ~pg_raw_i & pg_raw_o;
	assign climit_evt = climit_raw_i & ~climit_raw_o;

	// Raw status ignores masks; flags gated at detection time only
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pg_raw_o <= 1'b0;
			climit_raw_o <= 1'b0;
			pg_flag_set_o <= 1'b0;
			climit_flag_set_o <= 1'b0;
		end
		else
		begin
			pg_raw_o <= pg_raw_i;
			climit_raw_o <= climit_raw_i;
			// No memory of masked events, so unmasking later raises nothing
			pg_flag_set_o <= (pg_invalid_evt & ~fall_mask_i)
				| (pg_valid_evt & ~rise_mask_i);
			climit_flag_set_o <= climit_evt & ~climit_mask_i;
		end
	end

endmodule

// ==== design/_end.v ====
`timescale 1ns/1ns

// ==== verif/rim_checker.sv ====
// Port assertions for the mask block
`timescale 1ns/1ns
module rim_checker
(
	input logic clk_i,
	input logic rst_n_i,
	input logic [7:0] reg_addr_i,
	input logic [7:0] reg_wdata_i,
	input logic reg_we_i,
	input logic reg_re_i,
	input logic [7:0] reg_rdata_o,
	input logic reset_evt_i,
	input logic reset_flag_set_o,
	input logic conv0_pg_i,
	input logic conv0_climit_i,
	input logic [3:0] pg_raw_o,
	input logic [3:0] pg_flag_set_o,
	input logic [3:0] climit_flag_set_o
);
	logic [7:0] m_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Shadow of converter mask, reserved bits dropped
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i) m_q <= 8'hcc;
		else if (reg_we_i && reg_addr_i == 8'h22) m_q <= reg_wdata_i & 8'hdd;
	a_raw_follow: assert property ($past(rst_n_i) |->
		pg_raw_o[0] == $past(conv0_pg_i)) else $error("raw lag");
	a_fall_gate: assert property ($rose(conv0_pg_i) |=>
		pg_flag_set_o[0] == !$past(m_q[3])) else $error("fall gate");
	a_rise_gate: assert property ($fell(conv0_pg_i) |=>
		pg_flag_set_o[0] == !$past(m_q[2])) else $error("rise gate");
	a_clim_gate: assert property ($rose(conv0_climit_i) |=>
		climit_flag_set_o[0] == !$past(m_q[0])) else $error("clim gate");
	a_flag_cause: assert property (pg_flag_set_o[0] |->
		pg_raw_o[0] != $past(pg_raw_o[0])) else $error("stale flag");
	a_read_mask: assert property (reg_re_i && reg_addr_i == 8'h22 |=>
		reg_rdata_o == $past(m_q)) else $error("mask read");
	a_lin_resv: assert property (reg_re_i && reg_addr_i == 8'h23 |=>
		(reg_rdata_o & 8'h22) == 8'h00) else $error("reserved bit");
	a_evt_cause: assert property (reset_flag_set_o |->
		$past(reset_evt_i)) else $error("reset flag");
	c_fall: cover property ($rose(conv0_pg_i) && !m_q[3]);
	c_rflag: cover property (reset_flag_set_o);
	c_clim: cover property (climit_flag_set_o[0]);
endmodule

// ==== verif/rim_host.sv ====
// Host model driving the register port
`timescale 1ns/1ns
module rim_host
(
	input logic clk_i, // Clock
	input logic [7:0] rdata_i, // Read data
	output logic [7:0] addr_o, // Address
	output logic [7:0] wdata_o, // Write data
	output logic we_o, // Write strobe
	output logic re_o // Read strobe
);
	initial {addr_o, wdata_o, we_o, re_o} = '0;
	// Released lines show inverted values, never stale ones
	task automatic wr(input logic [7:0] a, dt);
		@(negedge clk_i);
		{addr_o, wdata_o, we_o} = {a, dt, 1'b1};
		@(negedge clk_i);
		{addr_o, wdata_o, we_o} = {~a, ~dt, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] dt);
		@(negedge clk_i);
		{addr_o, re_o} = {a, 1'b1};
		@(negedge clk_i);
		{addr_o, re_o} = {~a, 1'b0};
		dt = rdata_i;
	endtask
endmodule

// ==== verif/rim_bench.sv ====
// Self-checking bench for the mask block
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: %h not %h", $time, a, b); end end
module rim_bench;
	logic clk_i = 0, rst_n_i = 0, otp = 1, evt = 0, we, re, rflag;
	logic [3:0] pg = 0, cl = 0, pg_raw, cl_raw, pg_set, cl_set;
	logic [7:0] addr, wdata, rdata, d;
	int err_total = 0, num_checks = 0;
	// Rows: write flag, address, write data, expected read
	logic [27:0] rows [7] = '{28'h0210001, 28'h02200cc, 28'h02300cc,
		28'h122ffdd, 28'h123ffdd, 28'h121fefe, 28'h130ff00};
	rim_top i_rim_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
		.otp_reset_mask_i(otp), .reset_evt_i(evt), .conv0_pg_i(pg[0]),
		.conv0_climit_i(cl[0]), .conv1_pg_i(pg[1]), .conv1_climit_i(cl[1]),
		.lin0_pg_i(pg[2]), .lin0_climit_i(cl[2]), .lin1_pg_i(pg[3]),
		.lin1_climit_i(cl[3]), .reset_flag_set_o(rflag), .pg_raw_o(pg_raw),
		.climit_raw_o(cl_raw), .pg_flag_set_o(pg_set),
		.climit_flag_set_o(cl_set));
	rim_host i_rim_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .we_o(we), .re_o(re));
	initial forever #2 clk_i = ~clk_i;
	// Drive detect inputs, check pulses and raw one cycle on
	task automatic ev(input logic [3:0] p, c, ep, ec);
		@(negedge clk_i);
		{pg, cl} = {p, c};
		@(negedge clk_i);
		`CHK({pg_set, cl_set}, {ep, ec})
		`CHK({pg_raw, cl_raw}, {p, c})
	endtask
	task automatic evt_chk(input logic e);
		@(negedge clk_i);
		evt = 1;
		@(negedge clk_i);
		evt = 0;
		`CHK(rflag, e)
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge clk_i);
		rst_n_i = 1;
		foreach (rows[i])
		begin
			if (rows[i][24]) i_rim_host.wr(rows[i][23:16], rows[i][15:8]);
			i_rim_host.rd(rows[i][23:16], d);
			`CHK(d, rows[i][7:0])
		end
		evt_chk(1'b1);
		i_rim_host.wr(8'h21, 8'h01);
		evt_chk(1'b0);
		// Converter falls masked, linear rises masked
		i_rim_host.wr(8'h22, 8'h88);
		i_rim_host.wr(8'h23, 8'h44);
		ev(4'hf, 4'hf, 4'hc, 4'hf);
		ev(4'h0, 4'h0, 4'h3, 4'h0);
		i_rim_host.wr(8'h22, 8'hdd);
		ev(4'h3, 4'h0, 4'h0, 4'h0);
		// Unmasking later must not replay the dropped event
		i_rim_host.wr(8'h22, 8'h00);
		ev(4'h3, 4'h0, 4'h0, 4'h0);
		i_rim_host.wr(8'h23, 8'h55);
		ev(4'h3, 4'hf, 4'h0, 4'h3);
		ev(4'h0, 4'h0, 4'h3, 4'h0);
		// All unmasked: both transitions flag on every regulator
		i_rim_host.wr(8'h23, 8'h00);
		ev(4'hf, 4'h0, 4'hf, 4'h0);
		ev(4'h0, 4'h0, 4'hf, 4'h0);
		// Host write of the reset mask is lost across reset
		i_rim_host.wr(8'h21, 8'hfe);
		rst_n_i = 0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1;
		i_rim_host.rd(8'h21, d);
		`CHK(d, 8'h01)
		// A cleared OTP value must reach the mask, not the constant default
		otp = 0;
		rst_n_i = 0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1;
		i_rim_host.rd(8'h21, d);
		`CHK(d, 8'h00)
		evt_chk(1'b1);
		stop_test();
	end
endmodule
bind rim_top rim_checker i_rim_checker (.*);
